// >>> inc/touch_i2c_pkg.sv
// shared constants, types and states of the touch controller serial front end
`default_nettype none
package touch_i2c_pkg;

  localparam int MCLK_PERIOD_NS = 50;
  localparam int RST_FILT_NS    = 788;
  localparam int POR_US         = 20;
  // least times, so round up to whole cycles
  localparam int RST_FILT_CYC   = (RST_FILT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int POR_CYC        = (POR_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  localparam logic [6:0] ADDR_PIN_LOW  = 7'h40;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h41;
  localparam logic       RW_READ       = 1'b1;
  localparam logic       RW_WRITE      = 1'b0;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] ACK_SLOT      = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR_BYTE,
    ST_ACK_WR,
    ST_RD_BYTE,
    ST_RD_ACKCHK,
    ST_IGNORE
  } link_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_evt_t;

  typedef struct packed {
    logic busy;
    logic selected;
    logic read;
  } link_status_t;

endpackage : touch_i2c_pkg
`default_nettype wire

// >>> src/reset_supervisor.sv
// power-on reset interval and glitch filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor
  import touch_i2c_pkg::*;
#(
  parameter int FILT_CYC = RST_FILT_CYC,
  parameter int POR_LEN  = POR_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ext_reset_in_low,
  output var  logic core_rst
);

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int PW = $clog2(POR_LEN + 1);
  localparam logic [FW-1:0] FILT_TOP = FW'(FILT_CYC);
  localparam logic [FW-1:0] FILT_PRE = FW'(FILT_CYC - 1);
  localparam logic [PW-1:0] POR_TOP  = PW'(POR_LEN);

  logic          ext_q1_r;
  logic          ext_q2_r;
  logic [FW-1:0] filt_cnt_r;
  logic [FW-1:0] filt_cnt_nxt;
  logic [PW-1:0] por_cnt_r;
  logic [PW-1:0] por_cnt_nxt;
  logic          por_busy;
  logic          core_rst_nxt;

  assign por_busy = (por_cnt_r != POR_TOP);

  always_comb begin
    filt_cnt_nxt = filt_cnt_r;
    por_cnt_nxt  = por_cnt_r;
    // any high sample restarts the filter, so short glitches never reset
    if (ext_q2_r) begin
      filt_cnt_nxt = '0;
    end else if (filt_cnt_r != FILT_TOP) begin
      filt_cnt_nxt = filt_cnt_r + 1'b1;
    end
    if (por_busy) begin
      por_cnt_nxt = por_cnt_r + 1'b1;
    end
    core_rst_nxt = por_busy || (filt_cnt_r == FILT_TOP);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q1_r   <= 1'b1;
      ext_q2_r   <= 1'b1;
      filt_cnt_r <= '0;
      por_cnt_r  <= '0;
      core_rst   <= 1'b1;
    end else begin
      ext_q1_r   <= ext_reset_in_low;
      ext_q2_r   <= ext_q1_r;
      filt_cnt_r <= filt_cnt_nxt;
      por_cnt_r  <= por_cnt_nxt;
      core_rst   <= core_rst_nxt;
    end
  end

  // the core may only rise after the filter has seen its full run of low samples
  AST_FILTER_REJECT: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(core_rst) |-> ($past(filt_cnt_r) == FILT_TOP))
    else $error("reset pin glitch reached the core");

  AST_FILTER_HIT: assert property (@(posedge mclk) disable iff (!rst_n)
    (filt_cnt_r == FILT_PRE && !ext_q2_r) |-> ##2 core_rst)
    else $error("long reset pin low did not reset the core");

  AST_POR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(core_rst) |-> (por_cnt_r == POR_TOP))
    else $error("core left reset before the power-on interval ended");

endmodule : reset_supervisor
`default_nettype wire

// >>> src/touch_i2c_front.sv
// serial target front end: start/stop detection, address match, ack and byte moves
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_front
  import touch_i2c_pkg::*;
#(
  parameter int FILT_CYC = RST_FILT_CYC,
  parameter int POR_LEN  = POR_CYC
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         scl,
  input  wire logic         sda_i,
  output var  logic         sda_o,
  output var  logic         sda_oe,
  input  wire logic         ext_reset_in_low,
  input  wire logic         addr_select_pin,
  input  wire logic [7:0]   rd_data,
  output var  logic         rd_req,
  output var  byte_evt_t    wr_evt,
  output var  link_status_t status,
  output var  logic         core_reset
);

  logic rst_q1_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  reset_supervisor #(
    .FILT_CYC (FILT_CYC),
    .POR_LEN  (POR_LEN)
  ) u_rst (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .ext_reset_in_low (ext_reset_in_low),
    .core_rst         (core_reset)
  );

  // link side: one sample per serial clock rise, announced by a toggle
  logic samp_r;
  logic samp_nxt;
  logic tgl_r;
  logic tgl_nxt;

  always_comb begin
    samp_nxt = sda_i;
    tgl_nxt  = ~tgl_r;
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      samp_r <= 1'b1;
      tgl_r  <= 1'b0;
    end else begin
      samp_r <= samp_nxt;
      tgl_r  <= tgl_nxt;
    end
  end

  AST_SAMPLE_ON_RISE: assert property (@(posedge scl) disable iff (!rst_n)
    1'b1 |=> (samp_r == $past(sda_i)) && (tgl_r != $past(tgl_r)))
    else $error("data not captured on serial clock rise");

  // system side synchronisers; toggle gets two extra stages so the bit is settled
  logic [2:0] scl_q_r;
  logic [2:0] sda_q_r;
  logic [3:0] tgl_q_r;
  logic [1:0] bit_q_r;
  logic [1:0] sel_q_r;
  logic       core_rst_d_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r      <= 3'h7;
      sda_q_r      <= 3'h7;
      tgl_q_r      <= 4'h0;
      bit_q_r      <= 2'h3;
      sel_q_r      <= 2'h0;
      core_rst_d_r <= 1'b1;
    end else begin
      scl_q_r      <= {scl_q_r[1:0], scl};
      sda_q_r      <= {sda_q_r[1:0], sda_i};
      tgl_q_r      <= {tgl_q_r[2:0], tgl_r};
      bit_q_r      <= {bit_q_r[0], samp_r};
      sel_q_r      <= {sel_q_r[0], addr_select_pin};
      core_rst_d_r <= core_reset;
    end
  end

  logic scl_hi;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_evt;
  logic bit_val;

  assign scl_hi    = scl_q_r[1] && scl_q_r[2];
  assign start_det = scl_hi && sda_q_r[2] && !sda_q_r[1];
  assign stop_det  = scl_hi && !sda_q_r[2] && sda_q_r[1];
  assign scl_fall  = scl_q_r[2] && !scl_q_r[1];
  assign bit_evt   = tgl_q_r[3] ^ tgl_q_r[2];
  assign bit_val   = bit_q_r[1];

  // strap: follows the pin while in reset, frozen once reset is over
  logic [6:0] my_addr_r;
  logic [6:0] my_addr_nxt;

  always_comb begin
    my_addr_nxt = my_addr_r;
    if (core_reset) begin
      my_addr_nxt = sel_q_r[1] ? ADDR_PIN_HIGH : ADDR_PIN_LOW;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      my_addr_r <= ADDR_PIN_LOW;
    end else begin
      my_addr_r <= my_addr_nxt;
    end
  end

  AST_STRAP_FROZEN: assert property (@(posedge mclk) disable iff (!rst_n)
    (!core_reset && !core_rst_d_r) |-> $stable(my_addr_r))
    else $error("own address changed outside reset");

  // transaction engine
  link_state_t state_r;
  link_state_t state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic [7:0]  tx_r;
  logic [7:0]  tx_nxt;
  logic        oe_nxt;
  logic        rd_r;
  logic        rd_nxt;
  logic        sel_r;
  logic        sel_nxt;
  logic        rd_req_nxt;
  byte_evt_t   wr_evt_nxt;
  logic [7:0]  byte_in;

  assign byte_in = {sh_r[6:0], bit_val};

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    tx_nxt     = tx_r;
    oe_nxt     = sda_oe;
    rd_nxt     = rd_r;
    sel_nxt    = sel_r;
    rd_req_nxt = 1'b0;
    wr_evt_nxt = '{valid: 1'b0, data: wr_evt.data};
    if (core_reset) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
      sel_nxt   = 1'b0;
    end else if (start_det) begin
      // a repeated start also lands here and re-arms address reception
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
      sel_nxt   = 1'b0;
      rd_nxt    = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
      sel_nxt   = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (bit_evt) begin
            sh_nxt  = byte_in;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == BYTE_BITS - 4'h1) begin
              if (byte_in[7:1] == my_addr_r) begin
                state_nxt  = ST_ACK_ADDR;
                sel_nxt    = 1'b1;
                rd_nxt     = (byte_in[0] == RW_READ);
                rd_req_nxt = (byte_in[0] == RW_READ);
              end else begin
                state_nxt = ST_IGNORE;
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: begin
          // first fall opens the ack slot, second fall closes it
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_nxt  = 1'b1;
              cnt_nxt = ACK_SLOT;
            end else begin
              cnt_nxt = 4'h0;
              if (state_r == ST_ACK_ADDR && rd_r) begin
                state_nxt = ST_RD_BYTE;
                oe_nxt    = ~rd_data[7];
                tx_nxt    = {rd_data[6:0], 1'b0};
              end else begin
                state_nxt = ST_WR_BYTE;
                oe_nxt    = 1'b0;
              end
            end
          end
        end
        ST_WR_BYTE: begin
          if (bit_evt) begin
            sh_nxt  = byte_in;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == BYTE_BITS - 4'h1) begin
              state_nxt  = ST_ACK_WR;
              wr_evt_nxt = '{valid: 1'b1, data: byte_in};
            end
          end
        end
        ST_RD_BYTE: begin
          // data moves only on falls, so it is steady over each rise
          if (bit_evt) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_nxt    = 1'b0;
              state_nxt = ST_RD_ACKCHK;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACKCHK: begin
          if (bit_evt) begin
            if (bit_val) begin
              state_nxt = ST_IDLE;
              sel_nxt   = 1'b0;
            end else begin
              rd_req_nxt = 1'b1;
              cnt_nxt    = ACK_SLOT;
            end
          end else if (scl_fall && cnt_r == ACK_SLOT) begin
            state_nxt = ST_RD_BYTE;
            cnt_nxt   = 4'h0;
            oe_nxt    = ~rd_data[7];
            tx_nxt    = {rd_data[6:0], 1'b0};
          end
        end
        ST_IGNORE: begin
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      tx_r    <= 8'h00;
      rd_r    <= 1'b0;
      sel_r   <= 1'b0;
      sda_oe  <= 1'b0;
      sda_o   <= 1'b0;
      rd_req  <= 1'b0;
      wr_evt  <= '0;
      status  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      rd_r    <= rd_nxt;
      sel_r   <= sel_nxt;
      sda_oe  <= oe_nxt;
      sda_o   <= 1'b0;
      rd_req  <= rd_req_nxt;
      wr_evt  <= wr_evt_nxt;
      status  <= '{busy: (state_nxt != ST_IDLE), selected: sel_nxt, read: rd_nxt};
    end
  end

  AST_ACK_ONLY_OWN: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_ACK_ADDR) |-> (sh_r[7:1] == my_addr_r))
    else $error("acknowledging a foreign address");

  AST_ACK_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_ACK_ADDR && scl_fall && cnt_r == BYTE_BITS && !start_det
     && !stop_det && !core_reset) |=> sda_oe [*4])
    else $error("ack slot not driven low");

  AST_MISMATCH_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_IGNORE) |-> !sda_oe && !status.selected)
    else $error("data driven after address mismatch");

  AST_IDLE_WAITS: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_IDLE && !start_det) |=> (state_r == ST_IDLE) && !sda_oe)
    else $error("left idle without a start");

  AST_DIR_BIT: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_ACK_ADDR && scl_fall && cnt_r == ACK_SLOT && !start_det
     && !stop_det && !core_reset)
    |=> state_r == (($past(sh_r[0]) == RW_READ) ? ST_RD_BYTE : ST_WR_BYTE))
    else $error("direction bit misread");

  AST_NACK_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_RD_ACKCHK && bit_evt && bit_val && !start_det && !stop_det
     && !core_reset) |=> (state_r == ST_IDLE) ##1 !sda_oe [*3])
    else $error("kept sending after master nack");

endmodule : touch_i2c_front
`default_nettype wire

// >>> testbench/i2c_master_model.sv
// behavioural bus master: drives the serial clock and pulls the data wire low
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic m_oe
);
  // clock stands high between frames, as an idle bus does
  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w
  // also serves as a repeated start, entered with the clock low
  task automatic start();
    m_oe = 1'b0;
    w(10);
    scl = 1'b1;
    w(20);
    m_oe = 1'b1;
    w(20);
    scl = 1'b0;
    w(10);
  endtask : start
  task automatic stop();
    m_oe = 1'b1;
    w(10);
    scl = 1'b1;
    w(20);
    m_oe = 1'b0;
    w(30);
  endtask : stop
  // data moves only while the clock is low; sampled in mid-high
  task automatic bit_io(input logic b, output logic r);
    m_oe = ~b;
    w(15);
    scl = 1'b1;
    w(10);
    r = sda;
    w(10);
    scl = 1'b0;
    w(15);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ai, a);
  endtask : byte_io
endmodule : i2c_master_model
`default_nettype wire

// >>> testbench/touch_ctrl_i2c_slave_front_end_bench.sv
// self-checking bench for the serial target front end
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_i2c_slave_front_end_bench;
  import touch_i2c_pkg::*;
  localparam int FILT = 4;
  localparam int POR  = 20;
  logic         mclk;
  logic         nrst;
  logic         ext_reset_in_low;
  logic         addr_select_pin;
  logic [7:0]   rd_data;
  logic         scl;
  logic         m_oe;
  logic         sda_o;
  logic         sda_oe;
  logic         rd_req;
  byte_evt_t    wr_evt;
  link_status_t status;
  logic         core_reset;
  wire          sda;
  logic [7:0]   rd_q [2];
  logic [7:0]   last_wr;
  int           rd_n;
  int           wr_n;
  int           fails;
  int           compares;
  // pull-up on the data wire
  assign sda = ~(sda_oe | m_oe);
  touch_i2c_front #(.FILT_CYC(FILT), .POR_LEN(POR)) u_touch_i2c_front (
    .mclk(mclk), .nrst(nrst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .ext_reset_in_low(ext_reset_in_low), .addr_select_pin(addr_select_pin),
    .rd_data(rd_data), .rd_req(rd_req), .wr_evt(wr_evt), .status(status),
    .core_reset(core_reset));
  i2c_master_model u_i2c_master_model (.mclk(mclk), .sda(sda), .scl(scl), .m_oe(m_oe));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (wr_evt.valid === 1'b1) begin
      last_wr <= wr_evt.data;
      wr_n++;
    end
    #1;
    if (rd_req === 1'b1) begin
      rd_data = rd_q[rd_n[0]];
      rd_n++;
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w
  // address byte on the wire: own seven-bit address, then the direction bit
  function automatic logic [7:0] addr_byte(input logic pin, input logic rw);
    return {(pin ? ADDR_PIN_HIGH : ADDR_PIN_LOW), rw};
  endfunction : addr_byte
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // sends one address byte and returns the ack level seen in the ninth slot
  task automatic addr(input logic [7:0] a8, output logic a);
    logic [7:0] r;
    u_i2c_master_model.start();
    u_i2c_master_model.byte_io(a8, 1'b1, r, a);
  endtask : addr
  initial begin
    #(50 * 20000);
    fails++;
    close_out();
  end
  initial begin
    logic [7:0] r;
    logic [7:0] d;
    logic       a;
    int         n;
    nrst = 1'b0;
    ext_reset_in_low = 1'b1;
    addr_select_pin = 1'b0;
    rd_data = 8'h00;
    rd_n = 0;
    wr_n = 0;
    fails = 0;
    compares = 0;
    void'($urandom(46222));
    w(6);
    nrst = 1'b1;
    chk("core_reset", 8'h01, core_reset);
    n = 0;
    while (core_reset === 1'b1 && n < 200) begin
      w(1);
      n++;
    end
    chk("por length ok", 8'h01, n >= POR && n <= POR + 6);
    $display("test por done");
    // no start yet: leading 1 keeps the wire still while the clock is high
    u_i2c_master_model.byte_io(addr_byte(1'b0, RW_WRITE), 1'b1, r, a);
    chk("ack before start", 8'h01, a);
    chk("busy", 8'h00, status.busy);
    $display("test pre-start done");
    d = 8'($urandom);
    n = wr_n;
    addr(addr_byte(1'b0, RW_WRITE), a);
    chk("write addr ack", 8'h00, a);
    chk("status", 8'h06, status);
    u_i2c_master_model.byte_io(d, 1'b1, r, a);
    chk("data ack", 8'h00, a);
    chk("write byte", d, last_wr);
    chk("write events", n[7:0] + 8'h01, wr_n[7:0]);
    u_i2c_master_model.stop();
    $display("test write done");
    do d = 8'($urandom); while (d[7:1] == ADDR_PIN_LOW);
    n = wr_n;
    addr(d, a);
    chk("foreign addr ack", 8'h01, a);
    u_i2c_master_model.byte_io(8'($urandom), 1'b1, r, a);
    chk("ignored ack", 8'h01, a);
    chk("write events", n[7:0], wr_n[7:0]);
    u_i2c_master_model.stop();
    $display("test foreign done");
    rd_q[0] = 8'($urandom);
    rd_q[1] = 8'($urandom);
    // index byte first, then a repeated start turns the transfer around
    addr(addr_byte(1'b0, RW_WRITE), a);
    u_i2c_master_model.byte_io(8'($urandom), 1'b1, r, a);
    chk("index ack", 8'h00, a);
    addr(addr_byte(1'b0, RW_READ), a);
    chk("read addr ack", 8'h00, a);
    chk("status", 8'h07, status);
    u_i2c_master_model.byte_io(8'hFF, 1'b0, r, a);
    chk("read byte 0", rd_q[0], r);
    chk("sda_o", 8'h00, sda_o);
    u_i2c_master_model.byte_io(8'hFF, 1'b1, r, a);
    chk("read byte 1", rd_q[1], r);
    chk("busy after nack", 8'h00, status.busy);
    chk("read requests", 8'h02, rd_n[7:0]);
    u_i2c_master_model.stop();
    $display("test read done");
    addr_select_pin = 1'b1;
    ext_reset_in_low = 1'b0;
    w($urandom_range(FILT - 1, 1));
    ext_reset_in_low = 1'b1;
    w(30);
    chk("glitch ignored", 8'h00, core_reset);
    ext_reset_in_low = 1'b0;
    w(12);
    chk("pin reset", 8'h01, core_reset);
    ext_reset_in_low = 1'b1;
    w(10);
    chk("pin released", 8'h00, core_reset);
    // strap frozen now, pin free for its other use
    addr_select_pin = 1'b0;
    addr(addr_byte(1'b0, RW_WRITE), a);
    chk("old addr ack", 8'h01, a);
    u_i2c_master_model.stop();
    addr(addr_byte(1'b1, RW_WRITE), a);
    chk("strap addr ack", 8'h00, a);
    u_i2c_master_model.stop();
    $display("test strap done");
    close_out();
  end
endmodule : touch_ctrl_i2c_slave_front_end_bench
`default_nettype wire
